// ==== row_repair_pkg.sv ====
//==============================================================
//==============================================================
package row_repair_pkg;

	// Geometry
	localparam int BANKS  = 16;
	localparam int BANK_W = 4;
	localparam int ROW_W  = 18;
	localparam int DQ_W   = 8;
	localparam int PIN_W  = 7 + BANK_W + ROW_W + 2 * DQ_W;

	// Mode register select and bits
	localparam logic [2:0] MR_SEL_MR0  = 3'h0;
	localparam logic [2:0] MR_SEL_MR4  = 3'h4;
	localparam int         MR4_HARD_BIT = 13;
	localparam int         MR4_SOFT_BIT = 5;

	// Guard keys on address bits 11..7, bits 6..0 all ones
	localparam int KEY_MSB  = 11;
	localparam int KEY_LSB  = 7;
	localparam int FILL_MSB = 6;
	localparam logic [6:0] KEY_FILL = 7'h7f;
	localparam logic [3:0][4:0] GUARD_KEYS =
		{5'h07, 5'h17, 5'h0f, 5'h19};
	localparam logic [1:0] KEY_LAST = 2'h3;

	// Multipurpose readout location for repair support
	localparam logic [1:0] MPR_PAGE_RPR = 2'h2;
	localparam logic [1:0] MPR_LOC_RPR  = 2'h0;
	localparam int         MPR_HARD_BIT = 7;
	localparam int         MPR_SOFT_BIT = 6;
	localparam int         MPR_LOC_LSB  = 0;
	localparam int         MPR_PAGE_LSB = 2;
	localparam logic       HARD_SUP     = 1'b1;
	localparam logic       SOFT_SUP     = 1'b1;

	// Timing
	localparam int CLK_HZ    = 100_000_000;
	localparam int CHK_BEATS = 4;
	localparam int PGM_MS    = 1000;
	localparam int PGM_CYC_DEF = PGM_MS * (CLK_HZ / 1000);
	localparam logic [BANK_W-1:0] BA0_MASK = 4'h1;

	// Register map (byte addresses)
	localparam logic [7:0] REG_CFG   = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_BSEL  = 8'h08;
	localparam logic [7:0] REG_BINFO = 8'h0c;
	localparam logic [7:0] REG_MPR   = 8'h10;
	localparam int         WL_W      = 5;
	localparam logic [4:0] WL_RST    = 5'h09;
	localparam int         BINFO_ST_LSB = 30;

	typedef enum logic [1:0] {BK_EMPTY, BK_SOFT, BK_HARD} bank_state_t;
	typedef enum logic [2:0] {
		S_IDLE, S_KEY, S_ARMED, S_OPEN, S_WL, S_CHECK, S_PROG
	} seq_t;

	// Next bank state after a committed repair
	function automatic bank_state_t repair_next(bank_state_t cur,
		logic hard);
		if (cur == BK_HARD)
			return BK_HARD;
		return hard ? BK_HARD : BK_SOFT;
	endfunction : repair_next

	// Guard key compare for key number k
	function automatic logic key_match(logic [ROW_W-1:0] a,
		logic [1:0] k);
		return a[KEY_MSB:KEY_LSB] == GUARD_KEYS[k] &&
			a[FILL_MSB:0] == KEY_FILL;
	endfunction : key_match

	// Bank and its bank-address-bit-0 partner
	function automatic logic [BANKS-1:0] pair_mask(
		logic [BANK_W-1:0] b);
		logic [BANKS-1:0] m;
		m = '0;
		m[b] = 1'b1;
		m[b ^ BA0_MASK] = 1'b1;
		return m;
	endfunction : pair_mask

endpackage : row_repair_pkg

// ==== row_repair_sync.sv ====
`timescale 1ns/1ps
//==============================================================
// Two-stage synchroniser for pin inputs
//==============================================================
module row_repair_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t s_ff;
	sync_t nxt_s;

	// First stage feeds only the second
	always_comb begin
		nxt_s    = s_ff;
		nxt_s.s1 = d;
		nxt_s.s2 = s_ff.s1;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign q = s_ff.s2;
endmodule : row_repair_sync

// ==== row_repair.sv ====
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
//==============================================================
// Post package row repair control
//==============================================================
module row_repair
	import row_repair_pkg::*;
#(
	parameter int unsigned PGM_CYC = PGM_CYC_DEF
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Decoded command pins
	input  wire logic              cmd_mrs,
	input  wire logic              cmd_act,
	input  wire logic              cmd_wr,
	input  wire logic              cmd_ap,
	input  wire logic              cmd_pre,
	input  wire logic              cmd_ref,
	input  wire logic              cmd_mpr_rd,
	input  wire logic [BANK_W-1:0] cmd_bank,
	input  wire logic [ROW_W-1:0]  cmd_addr,
	input  wire logic [DQ_W-1:0]   dq_rise,
	input  wire logic [DQ_W-1:0]   dq_fall,
	// Repair status
	output logic                   hard_mode,
	output logic                   soft_mode,
	output logic      [7:0]        mpr_data,
	output logic                   mpr_valid,
	output logic      [BANKS-1:0]  refresh_skip,
	output logic                   retain_lost,
	output logic                   repair_busy
);

	//==========================================================
	// Pin synchronisation
	//==========================================================
	logic [PIN_W-1:0]  pins_q;
	logic              p_mrs;
	logic              p_act;
	logic              p_wr;
	logic              p_ap;
	logic              p_pre;
	logic              p_ref;
	logic              p_mpr;
	logic [BANK_W-1:0] p_bank;
	logic [ROW_W-1:0]  p_addr;
	logic [DQ_W-1:0]   p_dqr;
	logic [DQ_W-1:0]   p_dqf;

	// All command pins pass two flops
	row_repair_sync #(
		.W (PIN_W)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({cmd_mrs, cmd_act, cmd_wr, cmd_ap, cmd_pre, cmd_ref,
			cmd_mpr_rd, cmd_bank, cmd_addr, dq_rise, dq_fall}),
		.q   (pins_q)
	);

	// Unpack synchronised pins
	assign {p_mrs, p_act, p_wr, p_ap, p_pre, p_ref, p_mpr, p_bank,
		p_addr, p_dqr, p_dqf} = pins_q;

	//==========================================================
	// State
	//==========================================================
	typedef struct packed {
		seq_t                            seq;
		logic [1:0]                      kcnt;
		logic                            hard_en;
		logic                            soft_en;
		logic [BANK_W-1:0]               tbank;
		logic [ROW_W-1:0]                trow;
		logic                            tap;
		logic [31:0]                     tcnt;
		logic                            ok;
		logic [WL_W-1:0]                 wl;
		logic [BANK_W-1:0]               bsel;
		bank_state_t [BANKS-1:0]         bst;
		logic [BANKS-1:0][ROW_W-1:0]     brow;
		logic [31:0]                     rdata;
		logic [7:0]                      mpr_data;
		logic                            mpr_valid;
		logic [BANKS-1:0]                skip;
		logic                            lost;
		logic                            busy;
	} state_t;

	state_t s_ff;
	state_t nxt_s;

	logic       mr4_hit;
	logic       mr4_both;
	logic       any_cmd;
	logic       dq_zero;
	logic       ok_now;
	logic [1:0] mpr_page;
	logic [1:0] mpr_loc;

	// Command decode
	assign mr4_hit  = p_mrs && p_bank[2:0] == MR_SEL_MR4;
	assign mr4_both = p_addr[MR4_HARD_BIT] && p_addr[MR4_SOFT_BIT];
	assign any_cmd  = p_mrs | p_act | p_wr | p_pre | p_ref;
	assign dq_zero  = p_dqr == '0 && p_dqf == '0;
	assign ok_now   = s_ff.ok && dq_zero;
	assign mpr_page = p_addr[MPR_PAGE_LSB +: 2];
	assign mpr_loc  = p_addr[MPR_LOC_LSB +: 2];

	//==========================================================
	// Next state
	//==========================================================
	always_comb begin
		nxt_s           = s_ff;
		nxt_s.rdata     = '0;
		nxt_s.mpr_valid = 1'b0;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_CFG:  nxt_s.wl   = reg_wdata[WL_W-1:0];
				REG_BSEL: nxt_s.bsel = reg_wdata[BANK_W-1:0];
				default:  ;
			endcase
		end

		// Register reads, data stands one cycle later
		if (reg_rd) begin
			case (reg_addr)
				REG_CFG:   nxt_s.rdata[WL_W-1:0] = s_ff.wl;
				REG_STAT:  nxt_s.rdata[4:0] = {s_ff.busy, s_ff.lost,
					s_ff.soft_en, s_ff.hard_en, s_ff.seq != S_IDLE};
				REG_BSEL:  nxt_s.rdata[BANK_W-1:0] = s_ff.bsel;
				REG_BINFO: begin
					nxt_s.rdata[ROW_W-1:0] = s_ff.brow[s_ff.bsel];
					nxt_s.rdata[BINFO_ST_LSB +: 2] = s_ff.bst[s_ff.bsel];
				end
				REG_MPR: begin
					nxt_s.rdata[MPR_HARD_BIT] = HARD_SUP;
					nxt_s.rdata[MPR_SOFT_BIT] = SOFT_SUP;
				end
				default:   nxt_s.rdata = '0;
			endcase
		end

		// Multipurpose readout of repair support
		if (p_mpr) begin
			nxt_s.mpr_valid = 1'b1;
			nxt_s.mpr_data  = '0;
			if (mpr_page == MPR_PAGE_RPR && mpr_loc == MPR_LOC_RPR) begin
				nxt_s.mpr_data[MPR_HARD_BIT] = HARD_SUP;
				nxt_s.mpr_data[MPR_SOFT_BIT] = SOFT_SUP;
			end
		end

		// Mode register 4 writes steer the repair modes
		if (mr4_hit && !mr4_both && s_ff.seq != S_PROG) begin
			nxt_s.hard_en = p_addr[MR4_HARD_BIT];
			nxt_s.soft_en = p_addr[MR4_SOFT_BIT];
			nxt_s.kcnt    = '0;
			nxt_s.seq     = (p_addr[MR4_HARD_BIT] ||
				p_addr[MR4_SOFT_BIT]) ? S_KEY : S_IDLE;
			if (!p_addr[MR4_HARD_BIT]) begin
				nxt_s.skip = '0;
				nxt_s.lost = 1'b0;
			end
		end else begin
			case (s_ff.seq)
				S_IDLE: ;

				// Guard keys in order, any other command except a readout aborts
				S_KEY: begin
					if (p_mrs && p_bank == '0 &&
						key_match(p_addr, s_ff.kcnt)) begin
						nxt_s.kcnt = s_ff.kcnt + 2'h1;
						if (s_ff.kcnt == KEY_LAST)
							nxt_s.seq = S_ARMED;
					end else if (any_cmd) begin
						nxt_s.seq = S_IDLE;
					end
				end

				// Activate captures failing bank and row
				S_ARMED: begin
					if (p_act) begin
						nxt_s.tbank = p_bank;
						nxt_s.trow  = p_addr;
						nxt_s.seq   = S_OPEN;
					end
				end

				// Write starts the data check after write latency
				S_OPEN: begin
					if (p_wr) begin
						nxt_s.tap  = p_ap;
						nxt_s.tcnt = 32'(s_ff.wl);
						nxt_s.seq  = S_WL;
						if (s_ff.hard_en) begin
							if (p_ap) begin
								nxt_s.skip = pair_mask(s_ff.tbank);
							end else begin
								nxt_s.skip = '1;
								nxt_s.lost = 1'b1;
							end
						end
					end
				end

				// Count out write latency
				S_WL: begin
					if (s_ff.tcnt == '0) begin
						nxt_s.seq  = S_CHECK;
						nxt_s.tcnt = 32'(CHK_BEATS - 1);
						nxt_s.ok   = 1'b1;
					end else begin
						nxt_s.tcnt = s_ff.tcnt - 32'h1;
					end
				end

				// All data low on every beat, then commit
				S_CHECK: begin
					nxt_s.ok = ok_now;
					if (s_ff.tcnt == '0) begin
						nxt_s.seq  = S_IDLE;
						nxt_s.skip = '0;
						if (ok_now) begin
							nxt_s.bst[s_ff.tbank] = repair_next(
								s_ff.bst[s_ff.tbank], s_ff.hard_en);
							if (s_ff.bst[s_ff.tbank] != BK_HARD) begin
								nxt_s.brow[s_ff.tbank] = s_ff.trow;
							end
							if (s_ff.hard_en) begin
								nxt_s.seq  = S_PROG;
								nxt_s.skip = s_ff.skip;
								nxt_s.busy = 1'b1;
								nxt_s.tcnt = 32'(PGM_CYC - 1);
							end
						end
					end else begin
						nxt_s.tcnt = s_ff.tcnt - 32'h1;
					end
				end

				// Hard programming time
				S_PROG: begin
					if (s_ff.tcnt == '0) begin
						nxt_s.seq  = S_IDLE;
						nxt_s.busy = 1'b0;
						// Plain write form keeps refresh off until exit
						nxt_s.skip = {BANKS{s_ff.lost}};
					end else begin
						nxt_s.tcnt = s_ff.tcnt - 32'h1;
					end
				end

				default: nxt_s.seq = S_IDLE;
			endcase
		end
	end

	//==========================================================
	// State register
	//==========================================================
	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff     <= '0;
			s_ff.wl  <= WL_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from state
	assign reg_rdata    = s_ff.rdata;
	assign hard_mode    = s_ff.hard_en;
	assign soft_mode    = s_ff.soft_en;
	assign mpr_data     = s_ff.mpr_data;
	assign mpr_valid    = s_ff.mpr_valid;
	assign refresh_skip = s_ff.skip;
	assign retain_lost  = s_ff.lost;
	assign repair_busy  = s_ff.busy;

	//==========================================================
	// Checks
	//==========================================================
	logic hard_kept;
	logic others_kept;

	// Helper: hard rows never change, other banks untouched
	always_comb begin
		hard_kept   = 1'b1;
		others_kept = 1'b1;
		for (int i = 0; i < BANKS; i++) begin
			if (s_ff.bst[i] == BK_HARD && (nxt_s.bst[i] != BK_HARD ||
				nxt_s.brow[i] != s_ff.brow[i]))
				hard_kept = 1'b0;
			if (i != int'(s_ff.tbank) && (nxt_s.bst[i] != s_ff.bst[i] ||
				nxt_s.brow[i] != s_ff.brow[i]))
				others_kept = 1'b0;
		end
	end

	sequence s_mr4_both_req;
		mr4_hit && mr4_both;
	endsequence

	sequence s_check_fail;
		s_ff.seq == S_CHECK && s_ff.tcnt == '0 && !ok_now;
	endsequence

	sequence s_rpr_read;
		p_mpr && mpr_page == MPR_PAGE_RPR && mpr_loc == MPR_LOC_RPR;
	endsequence

	chk_modes_excl: assert property (
		@(posedge clk) disable iff (rst)
		!(hard_mode && soft_mode))
		else $error("soft and hard repair modes both on");

	chk_both_ignored: assert property (
		@(posedge clk) disable iff (rst)
		s_mr4_both_req |=> $stable(hard_mode) && $stable(soft_mode))
		else $error("enable of both modes was not ignored");

	chk_hard_kept: assert property (
		@(posedge clk) disable iff (rst)
		hard_kept)
		else $error("stored hard repair changed");

	chk_other_banks: assert property (
		@(posedge clk) disable iff (rst)
		others_kept)
		else $error("repair touched another bank");

	chk_mpr_bits: assert property (
		@(posedge clk) disable iff (rst)
		s_rpr_read |=> mpr_valid && mpr_data[MPR_HARD_BIT] == HARD_SUP
			&& mpr_data[MPR_SOFT_BIT] == SOFT_SUP)
		else $error("repair support readout wrong");

	chk_key_abort: assert property (
		@(posedge clk) disable iff (rst)
		s_ff.seq == S_KEY && !p_mrs && any_cmd |=> s_ff.seq == S_IDLE)
		else $error("guard key interruption not aborted");

	chk_dq_gate: assert property (
		@(posedge clk) disable iff (rst)
		s_check_fail |=> $stable(s_ff.bst) && s_ff.seq == S_IDLE)
		else $error("repair committed with data high");

	chk_skip_pair: assert property (
		@(posedge clk) disable iff (rst)
		s_ff.seq == S_OPEN && p_wr && p_ap && s_ff.hard_en |=>
			refresh_skip[s_ff.tbank] &&
			refresh_skip[s_ff.tbank ^ BA0_MASK] && !retain_lost)
		else $error("refresh exclusion set wrong");

	chk_wr_lost: assert property (
		@(posedge clk) disable iff (rst)
		s_ff.seq == S_OPEN && p_wr && !p_ap && s_ff.hard_en |=>
			retain_lost && refresh_skip == '1)
		else $error("plain write hard form kept refresh");

	chk_soft_reuse: assert property (
		@(posedge clk) disable iff (rst)
		s_ff.seq == S_CHECK && s_ff.tcnt == '0 && ok_now &&
			s_ff.soft_en && s_ff.bst[s_ff.tbank] == BK_SOFT |=>
			s_ff.bst[$past(s_ff.tbank)] == BK_SOFT &&
			s_ff.brow[$past(s_ff.tbank)] == $past(s_ff.trow))
		else $error("soft repair did not reuse row");

	chk_prog_busy: assert property (
		@(posedge clk) disable iff (rst)
		s_ff.seq == S_PROG |-> repair_busy && !soft_mode)
		else $error("programming without busy");

endmodule : row_repair

// ==== row_repair_ctl.sv ====
`timescale 1ns/1ps
//======
// Controller model on the command pins
//======
module row_repair_ctl
	import row_repair_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Command strobes
	output logic                   cmd_mrs,
	output logic                   cmd_act,
	output logic                   cmd_wr,
	output logic                   cmd_ap,
	output logic                   cmd_pre,
	output logic                   cmd_ref,
	output logic                   cmd_mpr_rd,
	// Address and data
	output logic      [BANK_W-1:0] cmd_bank,
	output logic      [ROW_W-1:0]  cmd_addr,
	output logic      [DQ_W-1:0]   dq_rise,
	output logic      [DQ_W-1:0]   dq_fall
);
	localparam logic [6:0] C_MRS = 7'h40;
	localparam logic [6:0] C_ACT = 7'h20;
	localparam logic [6:0] C_WR  = 7'h10;
	localparam logic [6:0] C_AP  = 7'h08;

	logic [6:0]        cmd_q  = 7'h0;
	logic              own    = 1'b0;
	logic              dq_own = 1'b0;
	logic [BANK_W-1:0] bank_q = '0;
	logic [ROW_W-1:0]  addr_q = '0;
	logic [15:0]       dq_q   = 16'h0;
	logic [31:0]       nz     = 32'h1;

	// Released lines show a pattern that moves every cycle
	always @(posedge clk) nz <= {nz[30:0], ~nz[31]};
	assign {cmd_mrs, cmd_act, cmd_wr, cmd_ap} = cmd_q[6:3];
	assign {cmd_pre, cmd_ref, cmd_mpr_rd} = cmd_q[2:0];
	assign cmd_bank = own ? bank_q : nz[3:0];
	assign cmd_addr = own ? addr_q : nz[17:0];
	assign {dq_fall, dq_rise} = dq_own ? dq_q : nz[31:16];

	// One command cycle, then the lines are released
	task automatic issue(input logic [6:0] s, input logic [3:0] b,
		input logic [ROW_W-1:0] a);
		@(posedge clk);
		cmd_q  <= s;
		bank_q <= b;
		addr_q <= a;
		own    <= 1'b1;
		@(posedge clk);
		cmd_q <= 7'h0;
		own   <= 1'b0;
	endtask : issue

	// Full repair sequence; bad picks a high beat, 8 for none,
	// 9 or 10 break the keys with a precharge or a refresh
	task automatic repair(input logic hard, input logic ap,
		input logic [3:0] b, input logic [ROW_W-1:0] row, input int wl,
		input int bad, input logic swap);
		issue(C_MRS, 4'h4, hard ? 18'h02000 : 18'h00020);
		for (int k = 0; k < 4; k++) begin
			if (k == 2 && bad > 8)
				issue(bad == 9 ? 7'h04 : 7'h02, 4'h0, 18'h0);
			issue(C_MRS, 4'h0, {6'h0, GUARD_KEYS[swap ? k ^ 1 : k],
				KEY_FILL});
		end
		issue(C_ACT, b, row);
		issue(ap ? C_WR | C_AP : C_WR, b, row);
		for (int i = 2; i <= wl + 6; i++) begin
			@(posedge clk);
			dq_own <= i >= wl + 2 && i <= wl + 5;
			dq_q <= i == wl + 2 + bad / 2 ?
				(bad % 2 ? 16'h8000 : 16'h0001) : 16'h0;
		end
	endtask : repair
endmodule : row_repair_ctl

// ==== tb_row_repair.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("unexpected %s expected %0h seen %0h", n, e, g); \
	end \
end
//======
// Bench for the row repair block
//======
module tb_row_repair
	import row_repair_pkg::*;
;
	localparam int PGM = 20;
	logic              clk = 1'b0, rst = 1'b1;
	logic [7:0]        reg_addr = 8'h0;
	logic [31:0]       reg_wdata = 32'h0, reg_rdata;
	logic              reg_wr = 1'b0, reg_rd = 1'b0;
	logic              cmd_mrs, cmd_act, cmd_wr, cmd_ap;
	logic              cmd_pre, cmd_ref, cmd_mpr_rd;
	logic [BANK_W-1:0] cmd_bank;
	logic [ROW_W-1:0]  cmd_addr;
	logic [DQ_W-1:0]   dq_rise, dq_fall, mpr_data;
	logic              hard_mode, soft_mode, mpr_valid;
	logic              retain_lost, repair_busy;
	logic [BANKS-1:0]  refresh_skip;
	int                err_count = 0, cmp_count = 0, wl = 9;
	logic [31:0]       seed = 32'h372b872e;
	bank_state_t       st [BANKS] = '{default: BK_EMPTY};
	logic [ROW_W-1:0]  rows [BANKS] = '{default: '0};

	always #5 clk = ~clk;

	row_repair #(.PGM_CYC(PGM)) DUT (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmd_mrs(cmd_mrs), .cmd_act(cmd_act), .cmd_wr(cmd_wr),
		.cmd_ap(cmd_ap), .cmd_pre(cmd_pre), .cmd_ref(cmd_ref),
		.cmd_mpr_rd(cmd_mpr_rd), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
		.dq_rise(dq_rise), .dq_fall(dq_fall), .hard_mode(hard_mode),
		.soft_mode(soft_mode), .mpr_data(mpr_data), .mpr_valid(mpr_valid),
		.refresh_skip(refresh_skip), .retain_lost(retain_lost),
		.repair_busy(repair_busy));

	row_repair_ctl ctl (
		.clk(clk), .cmd_mrs(cmd_mrs), .cmd_act(cmd_act), .cmd_wr(cmd_wr),
		.cmd_ap(cmd_ap), .cmd_pre(cmd_pre), .cmd_ref(cmd_ref),
		.cmd_mpr_rd(cmd_mpr_rd), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
		.dq_rise(dq_rise), .dq_fall(dq_fall));

	// Random source and helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [ROW_W-1:0] rrow();
		logic [31:0] v;
		v = xs();
		return v[ROW_W-1:0];
	endfunction : rrow

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// Register port cycles
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd_reg

	// Compare every bank with the model
	task automatic chk_banks();
		logic [31:0] d;
		for (int b = 0; b < BANKS; b++) begin
			wr_reg(REG_BSEL, b);
			rd_reg(REG_BINFO, d);
			`CHK("bank state", st[b], d[31:30])
			`CHK("bank row", rows[b], d[17:0])
		end
	endtask : chk_banks

	// One repair, its programming time and the exit
	task automatic do_rep(input logic hard, input logic ap,
		input logic [3:0] b, input logic [ROW_W-1:0] row, input int bad,
		input logic swap);
		int               n;
		logic             ok;
		logic [BANKS-1:0] m;
		ok = bad == 8 && !swap;
		m = '0;
		m[b] = 1'b1;
		m[b ^ 4'h1] = 1'b1;
		ctl.repair(hard, ap, b, row, wl, bad, swap);
		if (hard && ok) begin
			for (n = 0; n < 30 && repair_busy !== 1'b1; n++) tick();
			`CHK("busy start", 1'b1, repair_busy)
			if (n == 30) report_and_stop();
			`CHK("skip mask", ap ? m : {BANKS{1'b1}}, refresh_skip)
			`CHK("lost", !ap, retain_lost)
			for (n = 0; n < 100 && repair_busy === 1'b1; n++) tick();
			if (n == 100) begin
				err_count++;
				report_and_stop();
			end
			`CHK("busy length", PGM, n)
			`CHK("skip after", ap ? '0 : {BANKS{1'b1}}, refresh_skip)
		end else
			repeat (20) tick();
		if (ok && st[b] != BK_HARD) begin
			st[b] = hard ? BK_HARD : BK_SOFT;
			rows[b] = row;
		end
		ctl.issue(7'h40, 4'h4, 18'h0);
		repeat (4) tick();
		`CHK("modes off", 2'b00, {hard_mode, soft_mode})
		`CHK("skip off", '0, refresh_skip)
		`CHK("lost off", 1'b0, retain_lost)
	endtask : do_rep

	// Main sequence
	initial begin
		logic [31:0] d;
		int          n;
		logic [17:0] mv [6] = '{18'h2020, 18'h2000, 18'h2020, 18'h0,
			18'h0020, 18'h0};
		logic [1:0]  me [6] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b01, 2'b00};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_reg(REG_CFG, d);
		`CHK("cfg reset", 5'h09, d[4:0])
		rd_reg(REG_MPR, d);
		`CHK("support reg", 32'hc0, d)
		wr_reg(REG_STAT, 32'hffffffff);
		rd_reg(REG_STAT, d);
		`CHK("status ro", 32'h0, d)
		wr_reg(8'h14, 32'hffffffff);
		rd_reg(8'h14, d);
		`CHK("unmapped", 32'h0, d)
		$display("test registers done");
		for (int b = 0; b < 16; b++) begin
			ctl.issue(7'h01, 4'h0, {14'h0, b[3:0]});
			for (n = 0; n < 8 && mpr_valid !== 1'b1; n++) tick();
			if (n == 8) begin
				err_count++;
				report_and_stop();
			end
			`CHK("readout", b == 8 ? 8'hc0 : 8'h00, mpr_data)
		end
		$display("test readout done");
		for (int i = 0; i < 6; i++) begin
			ctl.issue(7'h40, 4'h4, mv[i]);
			repeat (4) tick();
			`CHK("modes", me[i], {hard_mode, soft_mode})
		end
		$display("test modes done");
		do_rep(1'b0, 1'b0, 4'h3, rrow(), 8, 1'b0);
		do_rep(1'b0, 1'b0, 4'h3, rrow(), 8, 1'b0);
		do_rep(1'b0, 1'b0, 4'h2, rrow(), 8, 1'b0);
		chk_banks();
		do_rep(1'b1, 1'b1, 4'h3, rrow(), 8, 1'b0);
		do_rep(1'b1, 1'b1, 4'h3, rrow(), 8, 1'b0);
		do_rep(1'b0, 1'b0, 4'h3, rrow(), 8, 1'b0);
		chk_banks();
		$display("test repair order done");
		wl = 5;
		wr_reg(REG_CFG, 32'h5);
		for (int b = 0; b < 8; b++)
			do_rep(b[0], 1'b1, 4'h6, rrow(), b, 1'b0);
		do_rep(1'b0, 1'b0, 4'h6, rrow(), 8, 1'b1);
		for (int b = 9; b < 11; b++)
			do_rep(b[0], 1'b1, 4'h6, rrow(), b, 1'b0);
		d = xs();
		do_rep(1'b1, 1'b0, d[3:0], rrow(), 8, 1'b0);
		chk_banks();
		$display("test refusals done");
		for (int i = 0; i < 6; i++) begin
			d = xs();
			for (int k = 0; k < BANKS && st[d[3:0]] == BK_HARD; k++)
				d[3:0] = d[3:0] + 4'h1;
			do_rep(1'b0, 1'b0, d[3:0], d[21:4], 8, 1'b0);
		end
		chk_banks();
		$display("test random done");
		report_and_stop();
	end

	// Watchdog for the whole run
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
endmodule : tb_row_repair
